// File: logic/chip_select_pkg.sv
`default_nettype none
// ============================================================
// shared constants and types for the chip-select unit
package chip_select_pkg;

  // select slots: index 0 is the boot select, 1..11 the general selects
  localparam int NUM_SEL = 12;
  localparam int PA_LOW_FIELDS = 7;

  // register byte offsets
  localparam logic [7:0] OFF_PA_LOW = 8'h00;
  localparam logic [7:0] OFF_PA_HIGH = 8'h04;
  localparam logic [7:0] OFF_BOOT_BASE = 8'h08;
  localparam logic [7:0] OFF_BOOT_OPT = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_SEL_FIRST = 8'h20;
  localparam logic [7:0] OFF_SEL_LAST = 8'h77;
  localparam logic [7:0] OFF_SEL_OPT = 8'h04;

  // base register fields
  localparam int BASE_ADDR_LO = 3;
  localparam int BASE_BLK_LO = 0;

  // option register fields
  localparam int OPT_MODE = 15;
  localparam int OPT_BYTE_LO = 13;
  localparam int OPT_RW_LO = 11;
  localparam int OPT_STRB = 10;
  localparam int OPT_ACK_LO = 6;
  localparam int OPT_SPACE_LO = 4;
  localparam int OPT_LEVEL_LO = 1;
  localparam int OPT_AUTOVEC = 0;

  // reset values
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [15:0] OPT_RST = 16'h0000;
  localparam logic [15:0] BOOT_BASE_RST = 16'h0006;
  localparam logic [15:0] BOOT_OPT_RST = 16'h7B60;
  localparam logic [1:0] PA_RST = 2'h1;

  // encodings
  localparam logic [1:0] SPACE_CPU = 2'h0;
  localparam logic [1:0] SPACE_USER = 2'h1;
  localparam logic [1:0] SPACE_SUPER = 2'h2;
  localparam logic [3:0] ACK_FAST = 4'hE;
  localparam logic [3:0] ACK_EXTERNAL = 4'hF;
  localparam logic [3:0] IACK_TYPE = 4'hF;
  localparam logic [2:0] FC_CPU = 3'h7;
  localparam logic [1:0] SIZ_BYTE = 2'h1;
  localparam logic [1:0] PA_PORT16 = 2'h3;

  // slow peripheral clock divider
  localparam logic [2:0] SLOW_CLK_LAST = 3'h7;

  typedef enum logic [1:0] {ACK_IDLE, ACK_WAIT, ACK_DONE} ack_state_t;

endpackage
`default_nettype wire

// File: logic/bus_cycle_if.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// attributes of the bus cycle now on the external bus
interface bus_cycle_if;
  logic [23:0] addr;
  logic [2:0] fc;
  logic rw_read;
  logic [1:0] siz;
  logic iack_internal;

  modport drive (output addr, fc, rw_read, siz, iack_internal);
  modport sense (input addr, fc, rw_read, siz, iack_internal);
endinterface
`default_nettype wire

// File: logic/select_match.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// compare one select's settings against the current cycle
module select_match (
  // settings
  input wire logic [15:0] base,
  input wire logic [15:0] opt,
  input wire logic [1:0] pin_assign,
  // cycle
  bus_cycle_if.sense cyc,
  // result
  output logic hit
);

  logic cpu;
  logic space_ok;
  logic addr_ok;
  logic rw_ok;
  logic byte_ok;
  logic iack_ok;
  logic lane_hi;
  logic lane_lo;
  logic [4:0] low_bit;
  logic [1:0] space;
  logic [1:0] byte_f;
  logic [2:0] level;

  // field decode and comparisons
  always_comb begin
    space = opt[chip_select_pkg::OPT_SPACE_LO +: 2];
    byte_f = opt[chip_select_pkg::OPT_BYTE_LO +: 2];
    level = opt[chip_select_pkg::OPT_LEVEL_LO +: 3];
    cpu = (cyc.fc == chip_select_pkg::FC_CPU);
    case (space)
      chip_select_pkg::SPACE_CPU: space_ok = cpu;
      chip_select_pkg::SPACE_USER: space_ok = !cpu && !cyc.fc[2];
      chip_select_pkg::SPACE_SUPER: space_ok = !cpu && cyc.fc[2];
      default: space_ok = !cpu;
    endcase
    // block size sets the lowest compared address bit
    case (base[chip_select_pkg::BASE_BLK_LO +: 3])
      3'h0: low_bit = 5'd11;
      3'h1: low_bit = 5'd13;
      3'h2: low_bit = 5'd14;
      3'h3: low_bit = 5'd16;
      3'h4: low_bit = 5'd17;
      3'h5: low_bit = 5'd18;
      3'h6: low_bit = 5'd19;
      default: low_bit = 5'd20;
    endcase
    addr_ok = 1'b1;
    for (int b = 11; b < 24; b++) begin
      if (5'(b) >= low_bit && cyc.addr[b] != base[b - 11 + chip_select_pkg::BASE_ADDR_LO]) begin
        addr_ok = 1'b0;
      end
    end
    rw_ok = cyc.rw_read ? opt[chip_select_pkg::OPT_RW_LO] : opt[chip_select_pkg::OPT_RW_LO + 1];
    lane_hi = !cyc.addr[0];
    lane_lo = cyc.addr[0] || (cyc.siz != chip_select_pkg::SIZ_BYTE);
    if (pin_assign == chip_select_pkg::PA_PORT16) begin
      byte_ok = (byte_f[1] && lane_hi) || (byte_f[0] && lane_lo);
    end else begin
      byte_ok = (byte_f != 2'h0);
    end
    // level mask only counts for cpu space; on-chip requests are left alone
    if (space == chip_select_pkg::SPACE_CPU) begin
      iack_ok = (cyc.addr[19:16] == chip_select_pkg::IACK_TYPE) && !cyc.iack_internal
        && (level == 3'h0 || level == cyc.addr[3:1]);
    end else begin
      iack_ok = 1'b1;
    end
    hit = pin_assign[1] && space_ok && addr_ok && rw_ok && byte_ok && iack_ok;
  end

endmodule // select_match
`default_nettype wire

// File: logic/chip_select_unit.sv
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - iack responses only for external request cycles
// - on-chip interrupt acknowledges get no select response
// - no vector supplied: autovector ends the cycle
// - general pin fields: low one, high from data
// - data lines default high; board may drive
// - general selects reset to documented defaults
// - general byte lanes reset disabled, no assertion
// - boot select serves vector fetch at zero
// - boot pin field high one, both bytes
// - boot port width from data line zero
// - boot base zero with 512 Kbyte block
// - boot options reset to documented defaults
// - level and autovector only in cpu space
// - async follows strobes, sync follows slow clock
// - ack field picks internal ack and waits
module chip_select_unit (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset configuration straps
  input wire logic [7:0] data_in,
  // external bus cycle
  input wire logic [23:0] addr,
  input wire logic [2:0] fc,
  input wire logic rw_read,
  input wire logic [1:0] siz,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic iack_internal,
  // select and termination outputs
  output logic [10:0] sel_n,
  output logic boot_select_n,
  output logic [1:0] data_size_ack_n,
  output logic autovector_request_n,
  output logic slow_peripheral_clock
);

  localparam int N = chip_select_pkg::NUM_SEL;

  // ==========================================================
  // state
  typedef struct packed {
    logic [N-1:0][1:0] pin_assign;
    logic [N-1:0][15:0] base;
    logic [N-1:0][15:0] opt;
    logic strapped;
    logic [2:0] div_cnt;
    logic slow_clk;
    logic [N-1:0] sel_n;
    chip_select_pkg::ack_state_t ack_state;
    logic [3:0] wait_cnt;
    logic [1:0] ack_n;
    logic autovec_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } unit_state_t;

  unit_state_t cur;
  unit_state_t next_cur;
  logic [N-1:0] hit;

  // ==========================================================
  // cycle attributes shared with the comparators
  bus_cycle_if cyc ();

  assign cyc.addr = addr;
  assign cyc.fc = fc;
  assign cyc.rw_read = rw_read;
  assign cyc.siz = siz;
  assign cyc.iack_internal = iack_internal;

  // one comparator per select
  generate
    for (genvar g = 0; g < N; g++) begin : g_match
      select_match u_match (
        .base(cur.base[g]),
        .opt(cur.opt[g]),
        .pin_assign(cur.pin_assign[g]),
        .cyc(cyc),
        .hit(hit[g])
      );
    end
  endgenerate

  // ==========================================================
  // next state
  logic slow_en;
  logic setup;
  logic wr;
  logic sel_reg;
  logic sel_is_opt;
  logic [3:0] sel_idx;
  logic [7:0] sel_off;
  logic [31:0] rd;
  logic rd_err;
  logic found;
  logic [3:0] pick;
  logic [3:0] ack_field;
  logic [15:0] pick_opt;

  always_comb begin
    next_cur = cur;
    // slow peripheral clock divider and its enable
    slow_en = (cur.div_cnt == chip_select_pkg::SLOW_CLK_LAST);
    next_cur.div_cnt = cur.div_cnt + 3'h1;
    next_cur.slow_clk = next_cur.div_cnt[2];

    // straps taken once, first clock after reset release
    if (!cur.strapped) begin
      next_cur.strapped = 1'b1;
      next_cur.pin_assign[0] = {1'b1, data_in[0]};
      for (int k = 1; k < N; k++) begin
        next_cur.pin_assign[k] = {data_in[((k - 1) % 7) + 1], 1'b1};
      end
    end

    // apb decode
    setup = psel && !penable;
    wr = psel && penable && cur.pready && pwrite;
    sel_off = paddr - chip_select_pkg::OFF_SEL_FIRST;
    sel_reg = (paddr >= chip_select_pkg::OFF_SEL_FIRST)
      && (paddr <= chip_select_pkg::OFF_SEL_LAST) && (paddr[1:0] == 2'h0);
    sel_idx = 4'(sel_off[7:3]) + 4'h1;
    sel_is_opt = (sel_off[2:0] == chip_select_pkg::OFF_SEL_OPT[2:0]);
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    if (sel_reg) begin
      rd[15:0] = sel_is_opt ? cur.opt[sel_idx] : cur.base[sel_idx];
    end else begin
      case (paddr)
        chip_select_pkg::OFF_PA_LOW: begin
          for (int k = 0; k < chip_select_pkg::PA_LOW_FIELDS; k++) begin
            rd[2*k +: 2] = cur.pin_assign[k];
          end
        end
        chip_select_pkg::OFF_PA_HIGH: begin
          for (int k = chip_select_pkg::PA_LOW_FIELDS; k < N; k++) begin
            rd[2*(k - chip_select_pkg::PA_LOW_FIELDS) +: 2] = cur.pin_assign[k];
          end
        end
        chip_select_pkg::OFF_BOOT_BASE: rd[15:0] = cur.base[0];
        chip_select_pkg::OFF_BOOT_OPT: rd[15:0] = cur.opt[0];
        chip_select_pkg::OFF_STATUS: begin
          rd[N-1:0] = ~cur.sel_n;
          rd[16] = !cur.ack_n[0] || !cur.ack_n[1];
          rd[17] = !cur.autovec_n;
          rd[18] = cur.slow_clk;
        end
        default: rd_err = 1'b1;
      endcase
    end

    // answer one cycle after setup, zero wait access phase
    next_cur.pready = setup;
    if (setup) begin
      next_cur.prdata = pwrite ? 32'h0000_0000 : rd;
      next_cur.pslverr = rd_err || (pwrite && paddr == chip_select_pkg::OFF_STATUS);
    end else begin
      next_cur.prdata = 32'h0000_0000;
      next_cur.pslverr = 1'b0;
    end

    // register writes take effect at the completing edge
    if (wr && !cur.pslverr) begin
      if (sel_reg) begin
        if (sel_is_opt) begin
          next_cur.opt[sel_idx] = pwdata[15:0];
        end else begin
          next_cur.base[sel_idx] = pwdata[15:0];
        end
      end else begin
        case (paddr)
          chip_select_pkg::OFF_PA_LOW: begin
            for (int k = 0; k < chip_select_pkg::PA_LOW_FIELDS; k++) begin
              next_cur.pin_assign[k] = pwdata[2*k +: 2];
            end
          end
          chip_select_pkg::OFF_PA_HIGH: begin
            for (int k = chip_select_pkg::PA_LOW_FIELDS; k < N; k++) begin
              next_cur.pin_assign[k] = pwdata[2*(k - chip_select_pkg::PA_LOW_FIELDS) +: 2];
            end
          end
          chip_select_pkg::OFF_BOOT_BASE: next_cur.base[0] = pwdata[15:0];
          chip_select_pkg::OFF_BOOT_OPT: next_cur.opt[0] = pwdata[15:0];
          default: next_cur.strapped = next_cur.strapped;
        endcase
      end
    end

    // select assertion; only cycles driven onto the external bus match
    for (int i = 0; i < N; i++) begin
      if (address_strobe_n) begin
        next_cur.sel_n[i] = 1'b1;
      end else if (cur.sel_n[i] && hit[i]) begin
        if (cur.opt[i][chip_select_pkg::OPT_MODE]) begin
          if (slow_en) begin
            next_cur.sel_n[i] = 1'b0;
          end
        end else if (!cur.opt[i][chip_select_pkg::OPT_STRB] || !data_strobe_n) begin
          next_cur.sel_n[i] = 1'b0;
        end
      end
    end

    // lowest asserted async select owns internal termination
    found = 1'b0;
    pick = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (!cur.sel_n[i] && !cur.opt[i][chip_select_pkg::OPT_MODE]) begin
        found = 1'b1;
        pick = 4'(i);
      end
    end
    pick_opt = cur.opt[pick];
    ack_field = pick_opt[chip_select_pkg::OPT_ACK_LO +: 4];

    // internal ack / autovector sequencer
    case (cur.ack_state)
      chip_select_pkg::ACK_IDLE: begin
        if (found && !address_strobe_n) begin
          if (pick_opt[chip_select_pkg::OPT_SPACE_LO +: 2] == chip_select_pkg::SPACE_CPU
              && pick_opt[chip_select_pkg::OPT_AUTOVEC]) begin
            next_cur.autovec_n = 1'b0;
            next_cur.ack_state = chip_select_pkg::ACK_DONE;
          end else if (ack_field == chip_select_pkg::ACK_EXTERNAL) begin
            next_cur.ack_state = chip_select_pkg::ACK_DONE;
          end else if (ack_field == chip_select_pkg::ACK_FAST || ack_field == 4'h0) begin
            next_cur.ack_n = (cur.pin_assign[pick] == chip_select_pkg::PA_PORT16)
              ? 2'h1 : 2'h2;
            next_cur.ack_state = chip_select_pkg::ACK_DONE;
          end else begin
            next_cur.wait_cnt = ack_field;
            next_cur.ack_state = chip_select_pkg::ACK_WAIT;
          end
        end
      end
      chip_select_pkg::ACK_WAIT: begin
        if (address_strobe_n) begin
          next_cur.ack_state = chip_select_pkg::ACK_IDLE;
        end else if (cur.wait_cnt == 4'h1) begin
          next_cur.ack_n = (cur.pin_assign[pick] == chip_select_pkg::PA_PORT16)
            ? 2'h1 : 2'h2;
          next_cur.ack_state = chip_select_pkg::ACK_DONE;
        end else begin
          next_cur.wait_cnt = cur.wait_cnt - 4'h1;
        end
      end
      chip_select_pkg::ACK_DONE: begin
        if (address_strobe_n) begin
          next_cur.ack_n = 2'h3;
          next_cur.autovec_n = 1'b1;
          next_cur.ack_state = chip_select_pkg::ACK_IDLE;
        end
      end
      default: next_cur.ack_state = chip_select_pkg::ACK_IDLE;
    endcase
  end

  // ==========================================================
  // state register and reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 1; i < N; i++) begin
        cur.base[i] <= chip_select_pkg::BASE_RST;
        cur.opt[i] <= chip_select_pkg::OPT_RST;
        cur.pin_assign[i] <= chip_select_pkg::PA_RST;
      end
      cur.base[0] <= chip_select_pkg::BOOT_BASE_RST;
      cur.opt[0] <= chip_select_pkg::BOOT_OPT_RST;
      cur.pin_assign[0] <= 2'h3;
      cur.strapped <= 1'b0;
      cur.div_cnt <= 3'h0;
      cur.slow_clk <= 1'b0;
      cur.sel_n <= '1;
      cur.ack_state <= chip_select_pkg::ACK_IDLE;
      cur.wait_cnt <= 4'h0;
      cur.ack_n <= 2'h3;
      cur.autovec_n <= 1'b1;
      cur.prdata <= 32'h0000_0000;
      cur.pready <= 1'b0;
      cur.pslverr <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from state flops
  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign boot_select_n = cur.sel_n[0];
  assign sel_n = cur.sel_n[N-1:1];
  assign data_size_ack_n = cur.ack_n;
  assign autovector_request_n = cur.autovec_n;
  assign slow_peripheral_clock = cur.slow_clk;

endmodule // chip_select_unit
`default_nettype wire

// File: sim/chip_select_unit_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port-level checks of the select unit
module chip_select_unit_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic pready,
  // bus cycle
  input wire logic [23:0] addr,
  input wire logic [2:0] fc,
  input wire logic address_strobe_n,
  input wire logic iack_internal,
  // selects and terminations
  input wire logic [10:0] sel_n,
  input wire logic boot_select_n,
  input wire logic [1:0] data_size_ack_n,
  input wire logic autovector_request_n,
  input wire logic slow_peripheral_clock
);
  // cycle type bits of the address
  logic [3:0] addr_type;
  assign addr_type = addr[19:16];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // slow clock halves
  sequence hi4;
    slow_peripheral_clock [*4];
  endsequence
  sequence lo4;
    !slow_peripheral_clock [*4];
  endsequence

  a_sel_after_strobe: assert property ((sel_n != 11'h7FF) |-> !$past(address_strobe_n))
    else $error("general select without strobe");
  a_boot_after_strobe: assert property (!boot_select_n |-> !$past(address_strobe_n))
    else $error("boot select without strobe");
  a_internal_iack_quiet: assert property (iack_internal [*2] |-> autovector_request_n)
    else $error("autovector on internal acknowledge");
  a_autovec_cpu_only: assert property (!autovector_request_n |-> $past(fc) == 3'h7)
    else $error("autovector outside cpu space");
  a_autovec_iack_type: assert property (!autovector_request_n |-> $past(addr_type) == 4'hF)
    else $error("autovector outside acknowledge cycle");
  a_ack_with_select: assert property ((data_size_ack_n != 2'b11)
    |-> ((sel_n != 11'h7FF) || !boot_select_n))
    else $error("acknowledge without select");
  a_ack_one_lane: assert property (data_size_ack_n != 2'b00)
    else $error("both acknowledge lanes low");
  a_strobe_release: assert property ($rose(address_strobe_n) |=> (sel_n == 11'h7FF)
    && boot_select_n && (data_size_ack_n == 2'b11) && autovector_request_n)
    else $error("outputs held after strobe end");
  a_slow_clock_duty: assert property ($rose(slow_peripheral_clock) |-> hi4 ##1 lo4)
    else $error("slow clock shape wrong");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
endmodule // chip_select_unit_asserts
`default_nettype wire

// File: sim/strap_board.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// board side of the data lines: straps in reset, busy bus after
module strap_board (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // strap level and data lines
  input wire logic [7:0] strap,
  output logic [7:0] data_in
);
  // straps driven actively during reset, lines keep moving after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_in <= strap;
    end else begin
      data_in <= ~data_in;
    end
  end
endmodule // strap_board
`default_nettype wire

// File: sim/test_chip_select_unit.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// self-checking bench of the select unit
module test_chip_select_unit;
  typedef struct packed {logic [7:0] strap; logic [1:0] ack;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, data_in, strap;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] addr;
  logic [2:0] fc;
  logic [1:0] siz, data_size_ack_n, k_cap;
  logic rw_read, address_strobe_n, data_strobe_n, iack_internal, er;
  logic [10:0] sel_n, s_cap;
  logic boot_select_n, autovector_request_n, slow_peripheral_clock, b_cap, v_cap;
  int miscompares = 0;
  int num_checks = 0;
  int n, i, j;
  row_t rows [2] = '{'{8'hFE, 2'b10}, '{8'h01, 2'b01}};

  chip_select_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_in(data_in), .addr(addr), .fc(fc), .rw_read(rw_read), .siz(siz),
    .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
    .iack_internal(iack_internal), .sel_n(sel_n), .boot_select_n(boot_select_n),
    .data_size_ack_n(data_size_ack_n), .autovector_request_n(autovector_request_n),
    .slow_peripheral_clock(slow_peripheral_clock));
  strap_board board_u (.pclk(pclk), .presetn(presetn), .strap(strap), .data_in(data_in));

  // clock and time-zero values
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, iack_internal} = 5'h00;
    {address_strobe_n, data_strobe_n, rw_read} = 3'h7;
    paddr = 8'h00; pwdata = 32'h0; addr = 24'h0; fc = 3'h6; siz = 2'h2; strap = 8'hFF;
  end

  // ============================================================
  // compare and report
  task close_out;
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_ok(input logic c);
    num_checks++;
    if (c !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: cycle count out of range", $time);
    end
  endtask

  // expected pin fields for a strap value
  function automatic logic [31:0] pa_exp(input logic [7:0] s, input int hi);
    logic [31:0] v;
    int k;
    v = 32'h0;
    for (k = 0; k < 12; k++)
      if ((k >= 7) == (hi != 0)) v[2*(k%7) +: 2] = (k == 0) ? {1'b1, s[0]} : {s[((k-1)%7)+1], 1'b1};
    return v;
  endfunction

  // ============================================================
  // drivers
  task do_reset(input logic [7:0] s);
    @(posedge pclk);
    strap <= s;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      close_out;
    end
  endtask
  // quiet: no termination expected, the full window is watched
  task cyc(input logic [23:0] a, input logic [2:0] f, input logic [1:0] sz, input logic ik,
    input logic quiet);
    @(posedge pclk);
    addr <= a; fc <= f; siz <= sz; iack_internal <= ik;
    address_strobe_n <= 1'b0; data_strobe_n <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (data_size_ack_n === 2'b11 && autovector_request_n === 1'b1 && n < 20);
    s_cap = sel_n; b_cap = boot_select_n; k_cap = data_size_ack_n; v_cap = autovector_request_n;
    address_strobe_n <= 1'b1; data_strobe_n <= 1'b1; iack_internal <= 1'b0;
    if (!quiet && k_cap === 2'b11 && v_cap === 1'b1) begin
      miscompares++;
      close_out;
    end
    repeat (2) @(posedge pclk);
  endtask

  // ============================================================
  // main sequence: strap rows, then hand cases
  initial begin
    for (i = 0; i < 2; i++) begin
      do_reset(rows[i].strap);
      apb(1'b0, chip_select_pkg::OFF_PA_LOW, 32'h0);
      chk(rd, pa_exp(rows[i].strap, 0));
      apb(1'b0, chip_select_pkg::OFF_PA_HIGH, 32'h0);
      chk(rd, pa_exp(rows[i].strap, 1));
      apb(1'b0, chip_select_pkg::OFF_BOOT_BASE, 32'h0);
      chk(rd, 32'h0000_0006);
      apb(1'b0, chip_select_pkg::OFF_BOOT_OPT, 32'h0);
      chk(rd, 32'h0000_7B60);
      for (j = 0; j < 22; j++) begin
        apb(1'b0, 8'(8'h20 + 4*j), 32'h0);
        chk(rd, 32'h0);
      end
      cyc(24'h000000, 3'h6, 2'h2, 1'b0, 1'b0);
      chk(32'(b_cap), 32'h0);
      chk(32'(k_cap), 32'(rows[i].ack));
      chk_ok(n > 10);
      chk(32'(s_cap), 32'h7FF);
    end
    // general select 0 as a 16-bit supervisor select, level and autovector ignored
    apb(1'b1, chip_select_pkg::OFF_PA_LOW, pa_exp(8'h01, 0) | 32'h0000_000C);
    apb(1'b1, 8'h20, 32'h0000_1000);
    apb(1'b1, 8'h24, 32'h0000_7BAB);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0000_1000);
    cyc(24'h100000, 3'h5, 2'h2, 1'b0, 1'b0);
    chk(32'(s_cap), 32'h7FE);
    chk(32'({b_cap, v_cap}), 32'h3);
    chk(32'(k_cap), 32'h1);
    chk_ok(n <= 4);
    // same select set up for external acknowledge with autovector
    apb(1'b1, 8'h20, 32'h0000_FFFB);
    apb(1'b1, 8'h24, 32'h0000_2BC1);
    cyc(24'hFFFFF5, 3'h7, 2'h1, 1'b0, 1'b0);
    chk(32'(v_cap), 32'h0);
    chk(32'(s_cap), 32'h7FE);
    cyc(24'hFFFFF5, 3'h7, 2'h1, 1'b1, 1'b1);
    chk_ok(n == 20);
    chk(32'(s_cap), 32'h7FF);
    // same select in sync mode: follows the slow clock, no internal ack
    apb(1'b1, 8'h20, 32'h0000_1000);
    apb(1'b1, 8'h24, 32'h0000_FBAB);
    cyc(24'h100000, 3'h5, 2'h2, 1'b0, 1'b1);
    chk(32'(s_cap), 32'h7FE);
    chk(32'({k_cap, v_cap}), 32'h7);
    // refused accesses
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, chip_select_pkg::OFF_STATUS, 32'h0000_FFFF);
    chk(32'(er), 32'h1);
    close_out;
  end
endmodule // test_chip_select_unit

bind chip_select_unit chip_select_unit_asserts chk_u (.pclk(pclk), .presetn(presetn),
  .pready(pready), .addr(addr), .fc(fc), .address_strobe_n(address_strobe_n),
  .iack_internal(iack_internal), .sel_n(sel_n), .boot_select_n(boot_select_n),
  .data_size_ack_n(data_size_ack_n), .autovector_request_n(autovector_request_n),
  .slow_peripheral_clock(slow_peripheral_clock));
`default_nettype wire
